// file: cpmc_cfg.svh
`ifndef CPMC_CFG_SVH
`define CPMC_CFG_SVH

// timing, in native units and derived cycles at 40 MHz
`define CPMC_CLK_PERIOD_NS      25
`define CPMC_WAKE_LONG_MS       2000
`define CPMC_WAKE_LONG_CYC      ((`CPMC_WAKE_LONG_MS * 1000000) / `CPMC_CLK_PERIOD_NS)
`define CPMC_WAKE_CNT_W         32

// register offsets of the plain register port
`define CPMC_ADDR_W             8
`define CPMC_OFS_CTRL           8'h00
`define CPMC_OFS_STATUS         8'h01
`define CPMC_OFS_UVLO_SEL       8'h02

// control register fields
`define CPMC_CTRL_SHIP_BIT      0
`define CPMC_CTRL_RAIL_BIT      1
`define CPMC_CTRL_CHG_BIT       2
`define CPMC_CTRL_RST           8'h06

// battery undervoltage threshold selection
`define CPMC_UVLO_SEL_W         3
`define CPMC_UVLO_SEL_RST       3'h0
`define CPMC_UVLO_SEL_MAX       3'h7

`define CPMC_UNMAPPED_RDATA     8'hff

`endif

// file: cpmc_pkg.sv
package cpmc_pkg;

    typedef enum logic [1:0] {
        CPMC_SHIP    = 2'b00,
        CPMC_LOWPWR  = 2'b01,
        CPMC_ACTBAT  = 2'b10,
        CPMC_CHARGER = 2'b11
    } cpmc_mode_t;

    // analog comparator results, sampled synchronously
    typedef struct packed {
        logic in_above_uvlo;
        logic in_above_ovp;
        logic bat_above_uvlo;
        logic bat_above_uvlo_hyst;
        logic bat_above_uvlo_max;
        logic bat_overcurrent;
        logic bat_inserted;
        logic charge_done;
    } cpmc_sense_t;

    // per-mode function enables
    typedef struct packed {
        logic serial_en;
        logic adc_en;
        logic event_en;
        logic osc_en;
        logic always_on_rail;
        logic ovp_en;
        logic ocp_en;
        logic charge_en;
        logic input_limit_en;
    } cpmc_func_t;

endpackage

// file: cpmc_power_mode.sv
// ----------------------------------------------------------------------------
// Functional notes
// R1: functions enabled per mode; serial, ADC, event only in charger/active battery
// R2: ship mode latched off until input valid or long button press released
// R3: ship request honoured regardless of charge allow input
// R4: battery insertion without input enters ship unless button held low
// R5: ship request with valid input waits until input removed
// R6: ship request with button low waits until button released
// R7: button exit from ship only when battery above highest undervoltage threshold
// R8: host clearing ship request while input valid cancels pending entry
// R9: watchdog expiry leaves ship request set; pending entry still completes
// R10: in ship only input undervoltage comparator and button stay active
// R11: low power needs request low, no input, button high, serial idle
// R12: low power keeps always-on rail and button; serial, ADC, oscillator off
// R13: output rail holds state selected by its enable bit in low power
// R14: leave low power when request pin high or input valid
// R15: input overvoltage with low power request runs in active battery mode
// R16: button low with low power request runs active battery until released
// R17: host holds button low after reset in low power until rails up
// R18: outside ship, no input, battery above threshold closes discharge switch
// R19: discharge overcurrent opens discharge switch
// R20: battery below threshold opens switch; recovery uses fixed hysteresis
// R21: charger mode runs ADC continuously and charges until termination
// R22: insertion raises rail, samples button; long press wakes, else ship (insertion leaves output_rail_on_o off until a wake)
// R23: one of four modes held, evaluated every clock while oscillator runs
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "cpmc_cfg.svh"

module cpmc_power_mode #(
    parameter int unsigned WAKE_LONG_CYC = `CPMC_WAKE_LONG_CYC
) (
    // clock and reset
    input  wire logic                        core_clk_i,
    input  wire logic                        resetn_i,
    // pins and sensing
    input  wire logic                        push_button_n_i,
    input  wire logic                        low_power_request_n_i,
    input  wire logic                        charge_allow_n_i,
    input  wire logic                        serial_busy_i,
    input  wire logic                        event_pending_i,
    input  wire logic                        watchdog_expired_i,
    input  wire cpmc_pkg::cpmc_sense_t       sense_i,
    // register port
    input  wire logic [`CPMC_ADDR_W-1:0]     reg_addr_i,
    input  wire logic [7:0]                  reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [7:0]                  reg_rdata_o,
    // mode and controls
    output cpmc_pkg::cpmc_mode_t             mode_o,
    output cpmc_pkg::cpmc_func_t             func_o,
    output logic                             discharge_switch_on_o,
    output logic                             output_rail_on_o,
    output logic                             charging_o,
    output logic                             ship_pending_o
);
    import cpmc_pkg::*;

    cpmc_mode_t                  mode_q;
    cpmc_mode_t                  mode_d;
    logic                        ship_request_bit_q;
    logic                        output_rail_enable_bit_q;
    logic                        charge_enable_bit_q;
    logic [`CPMC_UVLO_SEL_W-1:0] uvlo_sel_q;
    logic [`CPMC_WAKE_CNT_W-1:0] wake_cnt_q;
    logic                        wake_long_q;
    logic                        bat_prev_q;
    logic                        insert_wait_q;
    logic                        bat_ok_q;
    logic                        ocp_trip_q;
    logic                        rail_hold_q;
    logic                        wr_ctrl;
    logic                        serial_live;
    logic                        lp_allowed;
    logic                        ship_go;
    logic                        insert_evt;

    // ------------------------------------------------------------------------
    // function decode
    // ------------------------------------------------------------------------
    function automatic cpmc_func_t mode_funcs(input cpmc_mode_t m);
        cpmc_func_t f;
        f = '0;
        case (m)
            CPMC_CHARGER: begin
                f = '{serial_en: 1'b1, adc_en: 1'b1, event_en: 1'b1, osc_en: 1'b1,
                      always_on_rail: 1'b1, ovp_en: 1'b1, ocp_en: 1'b1,
                      charge_en: 1'b1, input_limit_en: 1'b1}; // R1 R21
            end
            CPMC_ACTBAT: begin
                f = '{serial_en: 1'b1, adc_en: 1'b1, event_en: 1'b1, osc_en: 1'b1,
                      always_on_rail: 1'b1, ovp_en: 1'b1, ocp_en: 1'b1,
                      charge_en: 1'b0, input_limit_en: 1'b0}; // R1
            end
            CPMC_LOWPWR: begin
                f = '0;
                f.always_on_rail = 1'b1; // R12
                f.ovp_en = 1'b1;
            end
            CPMC_SHIP: begin
                f = '0; // R10
            end
            default: begin
                f = '0;
            end
        endcase
        return f;
    endfunction

    assign serial_live = (mode_q == CPMC_CHARGER) || (mode_q == CPMC_ACTBAT);
    assign wr_ctrl     = reg_wr_i && serial_live && (reg_addr_i == `CPMC_OFS_CTRL);

    // ------------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------------
    // ship request ignores charge allow and the watchdog entirely
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ship_request_bit_q       <= 1'b0;
            output_rail_enable_bit_q <= 1'b1;
            charge_enable_bit_q      <= 1'b1;
        end else begin
            if (mode_q == CPMC_SHIP) begin
                ship_request_bit_q <= 1'b0;
            end else if (wr_ctrl) begin
                ship_request_bit_q       <= reg_wdata_i[`CPMC_CTRL_SHIP_BIT]; // R3 R8 R9
                output_rail_enable_bit_q <= reg_wdata_i[`CPMC_CTRL_RAIL_BIT];
                charge_enable_bit_q      <= reg_wdata_i[`CPMC_CTRL_CHG_BIT];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            uvlo_sel_q <= `CPMC_UVLO_SEL_RST;
        end else if (reg_wr_i && serial_live && reg_addr_i == `CPMC_OFS_UVLO_SEL) begin
            uvlo_sel_q <= reg_wdata_i[`CPMC_UVLO_SEL_W-1:0];
        end
    end

    // serial access dead outside charger and active battery modes
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i && serial_live) begin // R1
            case (reg_addr_i)
                `CPMC_OFS_CTRL:     reg_rdata_o <= {5'h00, charge_enable_bit_q,
                                                    output_rail_enable_bit_q, ship_request_bit_q};
                `CPMC_OFS_STATUS:   reg_rdata_o <= {1'b0, ocp_trip_q, bat_ok_q, ship_go,
                                                    insert_wait_q, discharge_switch_on_o, mode_q};
                `CPMC_OFS_UVLO_SEL: reg_rdata_o <= {5'h00, uvlo_sel_q};
                default:            reg_rdata_o <= `CPMC_UNMAPPED_RDATA;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // battery insertion and wake timing
    // ------------------------------------------------------------------------
    assign insert_evt = sense_i.bat_inserted && !bat_prev_q && !sense_i.in_above_uvlo;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bat_prev_q    <= 1'b0;
            insert_wait_q <= 1'b0;
        end else begin
            bat_prev_q <= sense_i.bat_inserted;
            if (insert_evt && !push_button_n_i) begin
                insert_wait_q <= 1'b1; // R22
            end else if (push_button_n_i || sense_i.in_above_uvlo || wake_long_q) begin
                insert_wait_q <= 1'b0;
            end
        end
    end

    // long press counter, runs while the button is held
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_cnt_q  <= '0;
            wake_long_q <= 1'b0;
        end else if (push_button_n_i) begin
            wake_cnt_q  <= '0;
            wake_long_q <= 1'b0;
        end else if (wake_cnt_q >= WAKE_LONG_CYC[`CPMC_WAKE_CNT_W-1:0] - 1'b1) begin
            wake_long_q <= 1'b1;
        end else begin
            wake_cnt_q <= wake_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // battery protection
    // ------------------------------------------------------------------------
    // comparator pair models the fixed hysteresis: trip low, recover high
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bat_ok_q <= 1'b0;
        end else if (!sense_i.bat_above_uvlo) begin
            bat_ok_q <= 1'b0; // R20
        end else if (sense_i.bat_above_uvlo_hyst) begin
            bat_ok_q <= 1'b1; // R20
        end
    end

    // overcurrent latches until the mode leaves battery operation
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ocp_trip_q <= 1'b0;
        end else if (sense_i.bat_overcurrent && func_o.ocp_en) begin
            ocp_trip_q <= 1'b1; // R19
        end else if (mode_q == CPMC_SHIP || mode_q == CPMC_CHARGER) begin
            ocp_trip_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------------------
    assign ship_go    = ship_request_bit_q && !sense_i.in_above_uvlo && push_button_n_i; // R5 R6
    assign lp_allowed = !low_power_request_n_i && !sense_i.in_above_uvlo && push_button_n_i
                        && !serial_busy_i && !event_pending_i; // R11

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            CPMC_SHIP: begin
                if (sense_i.in_above_uvlo) begin
                    mode_d = CPMC_CHARGER; // R2
                end else if (wake_long_q && push_button_n_i && sense_i.bat_above_uvlo_max) begin
                    mode_d = CPMC_ACTBAT; // R2 R7
                end
            end
            CPMC_LOWPWR: begin
                if (sense_i.in_above_uvlo && !sense_i.in_above_ovp) begin
                    mode_d = CPMC_CHARGER; // R14
                end else if (low_power_request_n_i || sense_i.in_above_ovp || !push_button_n_i) begin
                    mode_d = CPMC_ACTBAT; // R14 R15 R16
                end
            end
            CPMC_ACTBAT: begin
                if (ship_go) begin
                    mode_d = CPMC_SHIP;
                end else if (sense_i.in_above_uvlo && !sense_i.in_above_ovp) begin
                    mode_d = CPMC_CHARGER;
                end else if (lp_allowed && !sense_i.in_above_ovp) begin
                    mode_d = CPMC_LOWPWR; // R11 R16
                end
            end
            CPMC_CHARGER: begin
                if (!sense_i.in_above_uvlo) begin
                    mode_d = ship_go ? CPMC_SHIP : CPMC_ACTBAT; // R5
                end else if (sense_i.in_above_ovp) begin
                    mode_d = CPMC_ACTBAT;
                end
            end
            default: begin
                mode_d = CPMC_SHIP;
            end
        endcase
        if (insert_evt && push_button_n_i) begin
            mode_d = CPMC_SHIP; // R4 R22
        end else if (insert_wait_q && wake_long_q) begin
            mode_d = CPMC_ACTBAT; // R22
        end
    end

    // oscillator stopped in low power and ship: only wake paths above move it
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q <= CPMC_SHIP;
        end else begin
            mode_q <= mode_d; // R23
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_o         <= CPMC_SHIP;
            func_o         <= '0;
            ship_pending_o <= 1'b0;
        end else begin
            mode_o         <= mode_d;
            func_o         <= mode_funcs(mode_d); // R1 R10 R12
            ship_pending_o <= ship_request_bit_q && mode_q != CPMC_SHIP;
        end
    end

    // rail frozen at low power entry
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rail_hold_q      <= 1'b0;
            output_rail_on_o <= 1'b0;
        end else begin
            if (mode_q != CPMC_LOWPWR) begin
                rail_hold_q <= output_rail_enable_bit_q;
            end
            case (mode_d)
                CPMC_SHIP:   output_rail_on_o <= 1'b0;
                CPMC_LOWPWR: output_rail_on_o <= (mode_q == CPMC_LOWPWR) ? rail_hold_q
                                                 : output_rail_enable_bit_q; // R13
                default:     output_rail_on_o <= output_rail_enable_bit_q;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            discharge_switch_on_o <= 1'b0;
            charging_o            <= 1'b0;
        end else begin
            discharge_switch_on_o <= (mode_d != CPMC_SHIP) && !sense_i.in_above_uvlo
                                     && bat_ok_q && sense_i.bat_above_uvlo && !ocp_trip_q
                                     && !sense_i.bat_overcurrent; // R18 R19 R20
            charging_o <= (mode_d == CPMC_CHARGER) && charge_enable_bit_q
                          && !charge_allow_n_i && !sense_i.charge_done; // R21
        end
    end

endmodule // cpmc_power_mode

// file: cpmc_host_model.sv
`timescale 1ns/1ps

module cpmc_host_model
    import cpmc_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 resetn_i,
    // commands from the test sequence
    input  wire logic                 press_i,
    input  wire logic                 sleep_i,
    // device state seen by the host
    input  wire cpmc_pkg::cpmc_mode_t mode_i,
    // pins towards the device
    output logic                      push_button_n_o,
    output logic                      low_power_request_n_o
);
    import cpmc_pkg::*;

    logic hold_q;

    // ------------------------------------------------------------------------
    // button hold after a reset taken in low power
    // ------------------------------------------------------------------------
    // releasing early would abort the power-up, so hold until rails are back
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_q <= 1'b1;
        end else if (mode_i == CPMC_ACTBAT) begin
            hold_q <= 1'b0;
        end
    end

    assign push_button_n_o       = !(press_i || (hold_q && sleep_i));
    assign low_power_request_n_o = !sleep_i;

endmodule // cpmc_host_model

// file: cpmc_power_mode_sva.sv
`timescale 1ns/1ps

module cpmc_power_mode_sva
    import cpmc_pkg::*;
(
    // watched ports
    input wire logic                 core_clk_i,
    input wire logic                 resetn_i,
    input wire logic                 push_button_n_i,
    input wire logic                 low_power_request_n_i,
    input wire logic                 serial_busy_i,
    input wire logic                 event_pending_i,
    input wire cpmc_pkg::cpmc_sense_t sense_i,
    input wire cpmc_pkg::cpmc_mode_t  mode_o,
    input wire cpmc_pkg::cpmc_func_t  func_o,
    input wire logic                 discharge_switch_on_o,
    input wire logic                 output_rail_on_o
);
    import cpmc_pkg::*;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_enter_lp;
        mode_o == CPMC_LOWPWR && $past(mode_o) != CPMC_LOWPWR;
    endsequence
    sequence s_lp_wake;
        mode_o == CPMC_LOWPWR && (low_power_request_n_i || sense_i.in_above_uvlo || !push_button_n_i);
    endsequence

    AST_SHIP_OFF: assert property (mode_o == CPMC_SHIP |-> !func_o.serial_en && !func_o.adc_en
        && !func_o.event_en && !func_o.charge_en && !discharge_switch_on_o) else $error("ship mode left a function on");
    AST_SERIAL_MODE: assert property ((func_o.serial_en || func_o.adc_en || func_o.event_en)
        |-> mode_o inside {CPMC_ACTBAT, CPMC_CHARGER}) else $error("serial or adc on in wrong mode");
    AST_LP_FUNC: assert property (mode_o == CPMC_LOWPWR |-> func_o.always_on_rail && !func_o.osc_en
        && !func_o.serial_en) else $error("low power function set wrong");
    AST_LP_ENTRY: assert property (s_enter_lp |-> $past(!low_power_request_n_i && !sense_i.in_above_uvlo
        && push_button_n_i && !serial_busy_i && !event_pending_i)) else $error("low power entered early");
    AST_LP_EXIT: assert property (s_lp_wake |=> mode_o != CPMC_LOWPWR) else $error("low power not left");
    AST_LP_BTN: assert property (mode_o == CPMC_LOWPWR && !push_button_n_i && !sense_i.in_above_uvlo
        |=> mode_o == CPMC_ACTBAT) else $error("button did not wake to active battery");
    AST_RAIL_HOLD: assert property (mode_o == CPMC_LOWPWR && $past(mode_o) == CPMC_LOWPWR
        |-> $stable(output_rail_on_o)) else $error("output rail moved in low power");
    AST_CHG_ADC: assert property (mode_o == CPMC_CHARGER |-> func_o.adc_en
        && $past(sense_i.in_above_uvlo)) else $error("charger mode without input or adc");
    AST_SHIP_DEFER: assert property (mode_o == CPMC_SHIP && $past(mode_o) != CPMC_SHIP
        |-> $past(!sense_i.in_above_uvlo && push_button_n_i)) else $error("ship entered too soon");
    AST_OCP: assert property (sense_i.bat_overcurrent |=> !discharge_switch_on_o)
        else $error("switch closed during overcurrent");
    AST_UV: assert property (!sense_i.bat_above_uvlo && !sense_i.in_above_uvlo |=> !discharge_switch_on_o)
        else $error("switch closed below battery threshold");

endmodule // cpmc_power_mode_sva

// file: cpmc_power_mode_tb_top.sv
`timescale 1ns/1ps
`include "cpmc_cfg.svh"

module cpmc_power_mode_tb_top;
    import cpmc_pkg::*;

    localparam int unsigned WAKE = 20;

    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    logic        press    = 1'b0;
    logic        sleep    = 1'b0;
    logic        busy     = 1'b0;
    logic        evt      = 1'b0;
    logic        wdog     = 1'b0;
    logic        chg_n    = 1'b0;
    cpmc_sense_t sense    = 8'h32;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr   = 1'b0;
    logic        reg_rd   = 1'b0;
    logic [7:0]  reg_rdata;
    logic        btn_n;
    logic        lp_n;
    cpmc_mode_t  mode;
    cpmc_func_t  func;
    logic        dis_on;
    logic        rail_on;
    logic        charging;
    logic        pend;
    int          err_total = 0;
    int          cmp_count = 0;

    always #12.5 core_clk = ~core_clk;

    cpmc_host_model host_u (.core_clk_i(core_clk), .resetn_i(resetn), .press_i(press), .sleep_i(sleep),
        .mode_i(mode), .push_button_n_o(btn_n), .low_power_request_n_o(lp_n));

    cpmc_power_mode #(.WAKE_LONG_CYC(WAKE)) dut_u (.core_clk_i(core_clk), .resetn_i(resetn),
        .push_button_n_i(btn_n), .low_power_request_n_i(lp_n), .charge_allow_n_i(chg_n),
        .serial_busy_i(busy), .event_pending_i(evt), .watchdog_expired_i(wdog), .sense_i(sense),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .mode_o(mode), .func_o(func), .discharge_switch_on_o(dis_on),
        .output_rail_on_o(rail_on), .charging_o(charging), .ship_pending_o(pend));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        cmp("reg_rdata_o", exp, reg_rdata & m);
    endtask

    task automatic mode_is(input cpmc_mode_t exp, input int n);
        #1;
        for (int i = 0; i < n && mode !== exp; i++) begin
            tick(1);
        end
        cmp("mode_o", {6'h00, exp}, {6'h00, mode});
    endtask

    task automatic press_for(input int n);
        @(posedge core_clk) press <= 1'b1;
        repeat (n) @(posedge core_clk);
        press <= 1'b0;
        tick(3);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        tick(2);
        mode_is(CPMC_SHIP, 1);
        rd(`CPMC_OFS_CTRL, 8'hff, 8'h00);
        wr(`CPMC_OFS_CTRL, 8'h01);
        press_for(WAKE + 5);
        mode_is(CPMC_SHIP, 1);
        @(posedge core_clk) sense.bat_above_uvlo_max <= 1'b1;
        press_for(5);
        mode_is(CPMC_SHIP, 1);
        press_for(WAKE + 5);
        mode_is(CPMC_ACTBAT, 5);
        cmp("discharge_switch_on_o", 8'h01, {7'h00, dis_on});
        rd(`CPMC_OFS_CTRL, 8'hff, `CPMC_CTRL_RST);
        rd(8'h10, 8'hff, `CPMC_UNMAPPED_RDATA);
        rd(`CPMC_OFS_STATUS, 8'h03, 8'h02);
        // ship request while the button is down, watchdog firing meanwhile
        @(posedge core_clk) press <= 1'b1;
        chg_n <= 1'b1;
        wr(`CPMC_OFS_CTRL, 8'h07);
        @(posedge core_clk) wdog <= 1'b1;
        @(posedge core_clk) wdog <= 1'b0;
        tick(3);
        mode_is(CPMC_ACTBAT, 1);
        @(posedge core_clk) press <= 1'b0;
        mode_is(CPMC_SHIP, 5);
        @(posedge core_clk) sense.in_above_uvlo <= 1'b1;
        chg_n <= 1'b0;
        mode_is(CPMC_CHARGER, 5);
        tick(2);
        cmp("charging_o", 8'h01, {7'h00, charging});
        @(posedge core_clk) sense.charge_done <= 1'b1;
        tick(2);
        cmp("charging_o", 8'h00, {7'h00, charging});
        @(posedge core_clk) sense.charge_done <= 1'b0;
        wr(`CPMC_OFS_CTRL, 8'h07);
        wr(`CPMC_OFS_CTRL, 8'h06);
        @(posedge core_clk) sense.in_above_uvlo <= 1'b0;
        mode_is(CPMC_ACTBAT, 5);
        @(posedge core_clk) sense.in_above_uvlo <= 1'b1;
        mode_is(CPMC_CHARGER, 5);
        wr(`CPMC_OFS_CTRL, 8'h07);
        tick(5);
        mode_is(CPMC_CHARGER, 1);
        cmp("ship_pending_o", 8'h01, {7'h00, pend});
        @(posedge core_clk) sense.in_above_uvlo <= 1'b0;
        mode_is(CPMC_SHIP, 5);
        @(posedge core_clk) sense.in_above_uvlo <= 1'b1;
        mode_is(CPMC_CHARGER, 5);
        @(posedge core_clk) sense.in_above_uvlo <= 1'b0;
        mode_is(CPMC_ACTBAT, 5);
        // low power entry, wake sources and return
        @(posedge core_clk) busy <= 1'b1;
        sleep <= 1'b1;
        tick(5);
        mode_is(CPMC_ACTBAT, 1);
        @(posedge core_clk) busy <= 1'b0;
        mode_is(CPMC_LOWPWR, 5);
        rd(`CPMC_OFS_STATUS, 8'hff, 8'h00);
        @(posedge core_clk) press <= 1'b1;
        mode_is(CPMC_ACTBAT, 5);
        @(posedge core_clk) press <= 1'b0;
        mode_is(CPMC_LOWPWR, 5);
        @(posedge core_clk) sense.in_above_ovp <= 1'b1;
        mode_is(CPMC_ACTBAT, 5);
        @(posedge core_clk) sense.in_above_ovp <= 1'b0;
        evt <= 1'b1;
        tick(5);
        mode_is(CPMC_ACTBAT, 1);
        @(posedge core_clk) evt <= 1'b0;
        mode_is(CPMC_LOWPWR, 5);
        @(posedge core_clk) sleep <= 1'b0;
        mode_is(CPMC_ACTBAT, 5);
        // undervoltage with hysteresis, then overcurrent
        @(posedge core_clk) sense.bat_above_uvlo <= 1'b0;
        sense.bat_above_uvlo_hyst <= 1'b0;
        tick(3);
        cmp("discharge_switch_on_o", 8'h00, {7'h00, dis_on});
        @(posedge core_clk) sense.bat_above_uvlo <= 1'b1;
        tick(3);
        cmp("discharge_switch_on_o", 8'h00, {7'h00, dis_on});
        @(posedge core_clk) sense.bat_above_uvlo_hyst <= 1'b1;
        tick(3);
        cmp("discharge_switch_on_o", 8'h01, {7'h00, dis_on});
        @(posedge core_clk) sense.bat_overcurrent <= 1'b1;
        tick(3);
        cmp("discharge_switch_on_o", 8'h00, {7'h00, dis_on});
        @(posedge core_clk) sense.bat_overcurrent <= 1'b0;
        // battery insertion, button up then button down after a fresh reset
        sense.bat_inserted <= 1'b0;
        tick(2);
        @(posedge core_clk) sense.bat_inserted <= 1'b1;
        mode_is(CPMC_SHIP, 5);
        @(posedge core_clk) resetn <= 1'b0;
        sense.bat_inserted <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        press <= 1'b1;
        @(posedge core_clk) sense.bat_inserted <= 1'b1;
        tick(5);
        mode_is(CPMC_SHIP, 1);
        tick(WAKE);
        mode_is(CPMC_ACTBAT, 5);
        @(posedge core_clk) press <= 1'b0;
        tick(3);
        report_and_stop();
    end

    // the sequence needs roughly 210 cycles; 8000 means a hang
    initial begin
        #200us;
        err_total++;
        report_and_stop();
    end

endmodule // cpmc_power_mode_tb_top

bind cpmc_power_mode cpmc_power_mode_sva chk_u (.core_clk_i, .resetn_i, .push_button_n_i, .low_power_request_n_i,
    .serial_busy_i, .event_pending_i, .sense_i, .mode_o, .func_o, .discharge_switch_on_o, .output_rail_on_o);
